// ===== core/seq_pkg.sv
// Constants and types shared by the microprogram address sequencer
package seq_pkg;

    // Datapath widths and stack geometry
    localparam int ADDR_W      = 12;
    localparam int INSTR_W     = 4;
    localparam int STACK_DEPTH = 9;
    localparam int SP_W        = 4;

    // Common address type
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [SP_W-1:0]   sp_t;

    // Instruction codes on the instruction input
    localparam logic [INSTR_W-1:0] INS_JUMP_ZERO     = 4'h0;
    localparam logic [INSTR_W-1:0] INS_COND_CALL     = 4'h1;
    localparam logic [INSTR_W-1:0] INS_JUMP_MAP      = 4'h2;
    localparam logic [INSTR_W-1:0] INS_COND_JUMP     = 4'h3;
    localparam logic [INSTR_W-1:0] INS_PUSH_LOAD     = 4'h4;
    localparam logic [INSTR_W-1:0] INS_COND_CALL_REG = 4'h5;
    localparam logic [INSTR_W-1:0] INS_COND_VECTOR   = 4'h6;
    localparam logic [INSTR_W-1:0] INS_COND_JUMP_REG = 4'h7;
    localparam logic [INSTR_W-1:0] INS_REPEAT_STACK  = 4'h8;
    localparam logic [INSTR_W-1:0] INS_REPEAT_DIRECT = 4'h9;
    localparam logic [INSTR_W-1:0] INS_COND_RETURN   = 4'hA;
    localparam logic [INSTR_W-1:0] INS_COND_JUMP_POP = 4'hB;
    localparam logic [INSTR_W-1:0] INS_LOAD_CONT     = 4'hC;
    localparam logic [INSTR_W-1:0] INS_LOOP_END      = 4'hD;
    localparam logic [INSTR_W-1:0] INS_CONTINUE      = 4'hE;
    localparam logic [INSTR_W-1:0] INS_THREE_WAY     = 4'hF;

    // Next address source
    typedef enum logic [1:0] {SRC_DIRECT, SRC_COUNTER, SRC_UPC, SRC_STACK} src_e;

    // Stack operation for one cycle
    typedef enum logic [1:0] {STK_HOLD, STK_PUSH, STK_POP, STK_CLEAR} stack_op_e;

    // Register/counter operation for one cycle
    typedef enum logic [1:0] {CNT_HOLD, CNT_LOAD, CNT_DEC} cnt_op_e;

    // Reset values and the full stack pointer
    localparam addr_t ADDR_RST = 12'h000;
    localparam sp_t   SP_EMPTY = 4'h0;
    localparam sp_t   SP_FULL  = 4'h9;

    // Avalon register byte offsets
    localparam logic [3:0] OFF_STATUS  = 4'h0;
    localparam logic [3:0] OFF_COUNTER = 4'h4;
    localparam logic [3:0] OFF_UPC     = 4'h8;
    localparam logic [3:0] OFF_CONTROL = 4'hC;

    // Field positions
    localparam int STAT_FULL_BIT   = 4;
    localparam int CTRL_CLEAR_BIT  = 0;
    localparam int CTRL_FLOAT_BIT  = 1;

endpackage

// ===== core/seq_stack.sv
// Nine-entry return-address stack with its pointer
`timescale 1ns/1ps
`default_nettype none
module seq_stack #(
    parameter int DEPTH = seq_pkg::STACK_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Operation and data
    input  wire seq_pkg::stack_op_e stackOp,
    input  wire seq_pkg::addr_t    pushData,
    // State
    output seq_pkg::sp_t           stackPtr,
    output seq_pkg::addr_t         stackTop,
    output logic                   stackFullN
);
    seq_pkg::sp_t   spQ;          // Points at last written entry
    seq_pkg::sp_t   pushIdx;      // Entry a push writes
    seq_pkg::addr_t memQ [1:DEPTH]; // Entries, index 0 means empty

    // Push target: next entry, or the top when full
    assign pushIdx = (spQ == seq_pkg::sp_t'(DEPTH)) ? spQ : spQ + 4'h1;

    // Pointer update on the rising edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            spQ <= seq_pkg::SP_EMPTY;
        else unique case (stackOp)
            seq_pkg::STK_CLEAR: spQ <= seq_pkg::SP_EMPTY;
            seq_pkg::STK_PUSH:  spQ <= pushIdx;
            seq_pkg::STK_POP:   if (spQ != seq_pkg::SP_EMPTY) spQ <= spQ - 4'h1;
            seq_pkg::STK_HOLD:  spQ <= spQ;
        endcase
    end

    // One writer per entry
    for (genvar i = 1; i <= DEPTH; i++)
    begin : gEntry
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                memQ[i] <= seq_pkg::ADDR_RST;
            else if (stackOp == seq_pkg::STK_PUSH && pushIdx == seq_pkg::sp_t'(i))
                memQ[i] <= pushData;
        end
    end

    // Top of stack read without popping; empty reads zero
    assign stackTop   = (spQ == seq_pkg::SP_EMPTY) ? seq_pkg::ADDR_RST : memQ[spQ];
    assign stackPtr   = spQ;
    assign stackFullN = (spQ != seq_pkg::sp_t'(DEPTH));
endmodule
`default_nettype wire

// ===== core/seq_loop_counter.sv
// Loadable 12-bit down counter for loop control
`timescale 1ns/1ps
`default_nettype none
module seq_loop_counter #(
    parameter int WIDTH = seq_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire seq_pkg::cnt_op_e cntOp,
    input  wire logic [WIDTH-1:0] loadValue,
    // State
    output logic [WIDTH-1:0]      count,
    output logic                  countZero
);
    logic [WIDTH-1:0] countQ; // Counter value

    // Load, decrement or hold on the rising edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            countQ <= '0;
        else unique case (cntOp)
            seq_pkg::CNT_LOAD: countQ <= loadValue;
            seq_pkg::CNT_DEC:  countQ <= countQ - WIDTH'(1);
            default:           countQ <= countQ;
        endcase
    end

    // Zero test ends a loop after N + 1 passes
    assign countZero = (countQ == '0);
    assign count     = countQ;
endmodule
`default_nettype wire

// ===== core/microprogram_address_sequencer.sv
// Top of the microprogram address sequencer with decode and Avalon status port
`timescale 1ns/1ps
`default_nettype none
module microprogram_address_sequencer (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Sequencer inputs
    input  wire logic [3:0]            instrCodeIn,
    input  wire seq_pkg::addr_t        directIn,
    input  wire logic                  condCodeN,
    input  wire logic                  condTestEnableN,
    input  wire logic                  sequencerCarryIn,
    input  wire logic                  counterLoadN,
    input  wire logic                  outputEnableN,
    // Address outputs, three-state as value plus enable
    output seq_pkg::addr_t             nextAddrOut,
    output logic                       nextAddrOutEnN,
    // Flags and source strobes
    output logic                       stackFullN,
    output logic                       pipelineSelectN,
    output logic                       mapSelectN,
    output logic                       vectorSelectN,
    // Avalon-MM slave
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest
);

    // Decode results
    logic                 condPass;     // Condition test outcome
    seq_pkg::src_e        srcSel;       // Chosen address source
    seq_pkg::stack_op_e   stackOpInstr; // Stack op from instruction
    seq_pkg::stack_op_e   stackOp;      // Stack op after soft clear
    seq_pkg::cnt_op_e     cntOpInstr;   // Counter op from instruction
    seq_pkg::cnt_op_e     cntOp;        // Counter op after load pin

    // Datapath state
    seq_pkg::addr_t       upcQ;         // Microprogram counter
    seq_pkg::addr_t       upcD;         // Its next value
    seq_pkg::addr_t       loopRegCounter; // Register/counter value
    logic                 countZero;    // Counter reads zero
    seq_pkg::addr_t       stackTop;     // Top stack entry
    seq_pkg::sp_t         stackPtr;     // Stack pointer
    seq_pkg::addr_t       addrMux;      // Selected next address

    // Bus state
    logic                 ackQ;         // Second cycle of a request
    logic [31:0]          readDataQ;    // Registered read data
    logic                 floatQ;       // Software output float
    logic                 busReq;       // Read or write pending
    logic                 wrAccept;     // Write takes effect now
    logic                 ctrlHit;      // Write to control register
    logic                 softClear;    // Software stack clear pulse

    // Condition: low code passes, enable high forces pass
    assign condPass = condTestEnableN | ~condCodeN;

    // Instruction decode into source, stack and counter ops
    always_comb
    begin
        srcSel          = seq_pkg::SRC_UPC;
        stackOpInstr    = seq_pkg::STK_HOLD;
        cntOpInstr      = seq_pkg::CNT_HOLD;
        pipelineSelectN = 1'b0;
        mapSelectN      = 1'b1;
        vectorSelectN   = 1'b1;
        unique case (instrCodeIn)
            seq_pkg::INS_JUMP_ZERO:
            begin
                // Address zero, stack emptied
                srcSel       = seq_pkg::SRC_DIRECT;
                stackOpInstr = seq_pkg::STK_CLEAR;
            end
            seq_pkg::INS_COND_CALL:
            begin
                // Pass: branch and push return
                if (condPass)
                begin
                    srcSel       = seq_pkg::SRC_DIRECT;
                    stackOpInstr = seq_pkg::STK_PUSH;
                end
            end
            seq_pkg::INS_JUMP_MAP:
            begin
                // Mapping source drives direct inputs
                srcSel          = seq_pkg::SRC_DIRECT;
                pipelineSelectN = 1'b1;
                mapSelectN      = 1'b0;
            end
            seq_pkg::INS_COND_JUMP:
            begin
                // Pass: jump to direct inputs
                if (condPass)
                    srcSel = seq_pkg::SRC_DIRECT;
            end
            seq_pkg::INS_PUSH_LOAD:
            begin
                // Always push, load counter unless test fails
                stackOpInstr = seq_pkg::STK_PUSH;
                if (condPass)
                    cntOpInstr = seq_pkg::CNT_LOAD;
            end
            seq_pkg::INS_COND_CALL_REG:
            begin
                // Call to counter or direct address
                stackOpInstr = seq_pkg::STK_PUSH;
                srcSel       = condPass ? seq_pkg::SRC_DIRECT : seq_pkg::SRC_COUNTER;
            end
            seq_pkg::INS_COND_VECTOR:
            begin
                // Interrupt vector drives direct inputs
                pipelineSelectN = 1'b1;
                vectorSelectN   = 1'b0;
                if (condPass)
                    srcSel = seq_pkg::SRC_DIRECT;
            end
            seq_pkg::INS_COND_JUMP_REG:
            begin
                // Jump to counter or direct address
                srcSel = condPass ? seq_pkg::SRC_DIRECT : seq_pkg::SRC_COUNTER;
            end
            seq_pkg::INS_REPEAT_STACK:
            begin
                // Loop on stack top until count ends
                if (!countZero)
                begin
                    srcSel     = seq_pkg::SRC_STACK;
                    cntOpInstr = seq_pkg::CNT_DEC;
                end
                else
                    stackOpInstr = seq_pkg::STK_POP;
            end
            seq_pkg::INS_REPEAT_DIRECT:
            begin
                // Loop on direct address until count ends
                if (!countZero)
                begin
                    srcSel     = seq_pkg::SRC_DIRECT;
                    cntOpInstr = seq_pkg::CNT_DEC;
                end
            end
            seq_pkg::INS_COND_RETURN:
            begin
                // Pass: return through stack
                if (condPass)
                begin
                    srcSel       = seq_pkg::SRC_STACK;
                    stackOpInstr = seq_pkg::STK_POP;
                end
            end
            seq_pkg::INS_COND_JUMP_POP:
            begin
                // Pass: jump and discard top
                if (condPass)
                begin
                    srcSel       = seq_pkg::SRC_DIRECT;
                    stackOpInstr = seq_pkg::STK_POP;
                end
            end
            seq_pkg::INS_LOAD_CONT:
            begin
                // Load counter and fall through
                cntOpInstr = seq_pkg::CNT_LOAD;
            end
            seq_pkg::INS_LOOP_END:
            begin
                // Fail: loop back; pass: exit and pop
                if (condPass)
                    stackOpInstr = seq_pkg::STK_POP;
                else
                    srcSel = seq_pkg::SRC_STACK;
            end
            seq_pkg::INS_CONTINUE:
            begin
                // Sequential address only
                srcSel = seq_pkg::SRC_UPC;
            end
            seq_pkg::INS_THREE_WAY:
            begin
                // Pass exits; fail loops or jumps on count end
                if (!countZero)
                    cntOpInstr = seq_pkg::CNT_DEC;
                if (condPass)
                    stackOpInstr = seq_pkg::STK_POP;
                else if (!countZero)
                    srcSel = seq_pkg::SRC_STACK;
                else
                begin
                    srcSel       = seq_pkg::SRC_DIRECT;
                    stackOpInstr = seq_pkg::STK_POP;
                end
            end
        endcase
    end

    // Load pin overrides the instruction's counter op
    assign cntOp = counterLoadN ? cntOpInstr : seq_pkg::CNT_LOAD;

    // Software clear overrides the instruction's stack op
    assign stackOp = softClear ? seq_pkg::STK_CLEAR : stackOpInstr;

    // Four-way next address mux; code zero yields address zero
    always_comb
    begin
        unique case (srcSel)
            seq_pkg::SRC_DIRECT:
                addrMux = (instrCodeIn == seq_pkg::INS_JUMP_ZERO) ? seq_pkg::ADDR_RST : directIn;
            seq_pkg::SRC_COUNTER: addrMux = loopRegCounter;
            seq_pkg::SRC_UPC:     addrMux = upcQ;
            seq_pkg::SRC_STACK:   addrMux = stackTop;
        endcase
    end

    // Address pins and their drive enable
    assign nextAddrOut    = addrMux;
    assign nextAddrOutEnN = outputEnableN | floatQ;

    // Program counter holds next sequential address
    assign upcD = addrMux + seq_pkg::addr_t'(sequencerCarryIn);

    // Program counter register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            upcQ <= seq_pkg::ADDR_RST;
        else
            upcQ <= upcD;
    end

    // Register/counter
    seq_loop_counter #(
        .WIDTH     (seq_pkg::ADDR_W)
    ) uCounter (
        .clk       (clk),
        .rst_n     (rst_n),
        .cntOp     (cntOp),
        .loadValue (directIn),
        .count     (loopRegCounter),
        .countZero (countZero)
    );

    // Return stack pushes the program counter
    seq_stack #(
        .DEPTH      (seq_pkg::STACK_DEPTH)
    ) uStack (
        .clk        (clk),
        .rst_n      (rst_n),
        .stackOp    (stackOp),
        .pushData   (upcQ),
        .stackPtr   (stackPtr),
        .stackTop   (stackTop),
        .stackFullN (stackFullN)
    );

    // Bus handshake: every request answered on its second edge
    assign busReq          = avs_read | avs_write;
    assign avs_waitrequest = busReq & ~ackQ;
    assign wrAccept        = avs_write & ackQ;
    assign ctrlHit         = wrAccept & (avs_address == seq_pkg::OFF_CONTROL) & avs_byteenable[0];
    assign softClear       = ctrlHit & avs_writedata[seq_pkg::CTRL_CLEAR_BIT];
    assign avs_readdata    = readDataQ;

    // Acknowledge toggles for one cycle per request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ackQ <= 1'b0;
        else
            ackQ <= busReq & ~ackQ;
    end

    // Read data captured on the first edge of a read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            readDataQ <= 32'h0000_0000;
        else if (avs_read && !ackQ)
        begin
            unique case (avs_address)
                seq_pkg::OFF_STATUS:
                    readDataQ <= {27'h000_0000, ~stackFullN, stackPtr};
                seq_pkg::OFF_COUNTER:
                    readDataQ <= {20'h0_0000, loopRegCounter};
                seq_pkg::OFF_UPC:
                    readDataQ <= {20'h0_0000, upcQ};
                seq_pkg::OFF_CONTROL:
                    readDataQ <= {30'h0000_0000, floatQ, 1'b0};
                default:
                    readDataQ <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Control register: output float bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            floatQ <= 1'b0;
        else if (ctrlHit)
            floatQ <= avs_writedata[seq_pkg::CTRL_FLOAT_BIT];
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_push_room;
        stackOp == seq_pkg::STK_PUSH && stackFullN;
    endsequence

    sequence s_push_full;
        stackOp == seq_pkg::STK_PUSH && !stackFullN;
    endsequence

    property p_jump_zero;
        instrCodeIn == seq_pkg::INS_JUMP_ZERO |-> nextAddrOut == 12'h000 ##1 stackPtr == 4'h0;
    endproperty
    a_jump_zero: assert property (p_jump_zero) else $error("Code zero failed to reset");

    property p_upc;
        1'b1 |=> upcQ == $past(nextAddrOut) + 12'($past(sequencerCarryIn));
    endproperty
    a_upc: assert property (p_upc) else $error("Program counter not address plus carry");

    property p_load;
        !counterLoadN |=> loopRegCounter == $past(directIn);
    endproperty
    a_load: assert property (p_load) else $error("Counter missed load");

    property p_repeat_dec;
        counterLoadN && instrCodeIn == seq_pkg::INS_REPEAT_DIRECT && !countZero
            |-> nextAddrOut == directIn ##1 loopRegCounter == $past(loopRegCounter) - 12'h001;
    endproperty
    a_repeat_dec: assert property (p_repeat_dec) else $error("Repeat did not count down");

    property p_pop;
        stackOp == seq_pkg::STK_POP && stackPtr != 4'h0 |=> stackPtr == $past(stackPtr) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("Pop did not lower pointer");

    property p_pop_empty;
        stackOp == seq_pkg::STK_POP && stackPtr == 4'h0 |=> stackPtr == 4'h0;
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("Empty pop moved pointer");

    property p_push;
        s_push_room |=> stackPtr == $past(stackPtr) + 4'h1 && stackTop == $past(upcQ);
    endproperty
    a_push: assert property (p_push) else $error("Push wrong pointer or data");

    property p_push_full;
        s_push_full |=> stackPtr == 4'h9 && !stackFullN && stackTop == $past(upcQ);
    endproperty
    a_push_full: assert property (p_push_full) else $error("Full push misbehaved");

    property p_full_flag;
        s_push_room ##0 stackPtr == 4'h8 |=> !stackFullN;
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("Full flag not low at nine");

    property p_selects;
        $onehot({~pipelineSelectN, ~mapSelectN, ~vectorSelectN});
    endproperty
    a_selects: assert property (p_selects) else $error("Select strobes not one-hot");

    property p_float;
        outputEnableN |-> nextAddrOutEnN;
    endproperty
    a_float: assert property (p_float) else $error("Outputs driven while disabled");

    property p_cond_fail;
        instrCodeIn == seq_pkg::INS_COND_JUMP && !condTestEnableN && condCodeN |-> nextAddrOut == upcQ;
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("Failed test still jumped");

    property p_cond_forced;
        instrCodeIn == seq_pkg::INS_COND_JUMP && condTestEnableN |-> nextAddrOut == directIn;
    endproperty
    a_cond_forced: assert property (p_cond_forced) else $error("Forced pass did not jump");

    property p_push_load_hold;
        counterLoadN && instrCodeIn == seq_pkg::INS_PUSH_LOAD && !condPass
            |=> $stable(loopRegCounter);
    endproperty
    a_push_load_hold: assert property (p_push_load_hold) else $error("Counter changed on failed test");

endmodule
`default_nettype wire

// ===== bench/seq_control_store.sv
// Control store side model: the address level that the memory sees
`timescale 1ns/1ps
`default_nettype none
module seq_control_store (
    // Sequencer address pins
    input  wire seq_pkg::addr_t nextAddrOut,
    input  wire logic           nextAddrOutEnN,
    // Level decoded by the memory
    output var seq_pkg::addr_t  busAddr
);
    // Floated pins give the inverted value, never the held value
    assign busAddr = nextAddrOutEnN ? ~nextAddrOut : nextAddrOut;
endmodule
`default_nettype wire

// ===== bench/microprogram_address_sequencer_tb_top.sv
// Testbench for the microprogram address sequencer
`timescale 1ns/1ps
`default_nettype none
module microprogram_address_sequencer_tb_top;
    // Stimulus, all given a value at time zero
    logic           clk = 0, rst_n = 0, sequencerCarryIn = 0, outputEnableN = 0, avs_read = 0, avs_write = 0;
    logic           condCodeN = 1, condTestEnableN = 1, counterLoadN = 1;
    logic [3:0]     instrCodeIn = 4'hE, avs_address = 4'h0;
    seq_pkg::addr_t directIn = 12'h000, nextAddrOut, busAddr;
    logic [31:0]    avs_writedata = 32'h0, avs_readdata, v;
    logic           nextAddrOutEnN, stackFullN, pipelineSelectN, mapSelectN, vectorSelectN, avs_waitrequest;
    int             failCount = 0, numChecks = 0, cycles = 0, hits;

    // Design and control store model
    microprogram_address_sequencer u_dut (.clk, .rst_n, .instrCodeIn, .directIn, .condCodeN, .condTestEnableN,
        .sequencerCarryIn, .counterLoadN, .outputEnableN, .nextAddrOut, .nextAddrOutEnN, .stackFullN,
        .pipelineSelectN, .mapSelectN, .vectorSelectN, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest);
    seq_control_store u_store (.nextAddrOut, .nextAddrOutEnN, .busAddr);

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    // Avalon transfer held until waitrequest is low at an edge
    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge clk);
    endtask

    // One instruction cycle, outputs looked at mid-cycle
    task automatic step(input logic [3:0] i, input logic [11:0] d, input logic t, input logic c, input logic ci,
        input logic l);
        @(posedge clk);
        instrCodeIn <= i;
        directIn <= d;
        condTestEnableN <= t;
        condCodeN <= c;
        sequencerCarryIn <= ci;
        counterLoadN <= l;
        @(negedge clk);
    endtask

    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // 40 MHz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failCount++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        step(4'h3, 12'h123, 1'b0, 1'b1, 1'b0, 1'b1);
        chk(nextAddrOut, 12'h000);
        step(4'h3, 12'h123, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(nextAddrOut, 12'h123);
        step(4'hE, 12'h000, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(nextAddrOut, 12'h124);
        $display("test condition done");
        step(4'h0, 12'h000, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(nextAddrOut, 12'h000);
        // Ten pushes: nine fill, the tenth overwrites the top
        for (int k = 0; k < 10; k++)
        begin
            step(4'h4, (k == 0) ? 12'h005 : 12'h007, k == 0, 1'b1, 1'b1, 1'b1);
            chk(nextAddrOut, 12'(k + 1));
            chk(stackFullN, k < 9);
        end
        // Stop pushing so the tenth push is the only overwrite
        step(4'hE, 12'h000, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(stackFullN, 1'b0);
        avs(1'b0, 4'h0, 32'h0);
        chk(v, 32'h19);
        avs(1'b0, 4'h4, 32'h0);
        chk(v, 32'h5);
        step(4'hA, 12'h000, 1'b1, 1'b1, 1'b1, 1'b1); // Pop before any new push
        chk(nextAddrOut, 12'h00A);
        step(4'hA, 12'h000, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(nextAddrOut, 12'h008);
        $display("test stack done");
        // Load two, repeat on direct input
        step(4'hE, 12'h002, 1'b1, 1'b1, 1'b1, 1'b0);
        hits = 0;
        for (int k = 0; k < 4; k++)
        begin
            step(4'h9, 12'h0AA, 1'b1, 1'b1, 1'b1, 1'b1);
            hits += (nextAddrOut === 12'h0AA);
        end
        chk(hits, 2);
        $display("test counter done");
        // Source strobes for every code
        for (int k = 0; k < 16; k++)
        begin
            step(4'(k), 12'h000, 1'b0, 1'b1, 1'b0, 1'b1);
            chk({pipelineSelectN, mapSelectN, vectorSelectN}, (k == 2) ? 3'h5 : (k == 6) ? 3'h6 : 3'h3);
        end
        // One push, then the software stack clear
        step(4'h4, 12'h000, 1'b1, 1'b1, 1'b0, 1'b1);
        step(4'hE, 12'h000, 1'b1, 1'b1, 1'b0, 1'b1);
        avs(1'b0, 4'h0, 32'h0);
        chk(v, 32'h1);
        avs(1'b1, 4'hC, 32'h1);
        avs(1'b0, 4'h0, 32'h0);
        chk(v, 32'h0);
        // Unmapped read, float bit, output enable pin
        avs(1'b0, 4'h2, 32'h0);
        chk(v, 32'h0);
        avs(1'b1, 4'hC, 32'h2);
        chk(nextAddrOutEnN, 1'b1);
        avs(1'b1, 4'hC, 32'h0);
        chk(busAddr, nextAddrOut);
        @(posedge clk);
        outputEnableN <= 1'b1;
        @(negedge clk);
        chk(nextAddrOutEnN, 1'b1);
        $display("test bus done");
        give_verdict();
    end
endmodule
`default_nettype wire
